/* File: shared/cncfg_defs.svh */
`ifndef CNCFG_DEFS_SVH
`define CNCFG_DEFS_SVH

// register byte offsets
`define CNCFG_OFF_CONFIG 8'h00
`define CNCFG_OFF_STATE 8'h04
`define CNCFG_OFF_WHEEL0 8'h08
`define CNCFG_OFF_WHEEL1 8'h0C
`define CNCFG_OFF_WHEEL2 8'h10
`define CNCFG_OFF_IRQ_STAT 8'h14
`define CNCFG_OFF_IRQ_MASK 8'h18

// config register fields (read only)
`define CNCFG_CFG_OPEN_BIT 0
`define CNCFG_CFG_RATE_LSB 1
`define CNCFG_CFG_NODE_LSB 4
`define CNCFG_CFG_DONE_BIT 12

// state register fields (software written)
`define CNCFG_ST_NMT_LSB 0
`define CNCFG_ST_CONFIG_BIT 2
`define CNCFG_ST_WARN_BIT 3
`define CNCFG_ST_LOST_BIT 4
`define CNCFG_ST_BUSOFF_BIT 5
`define CNCFG_ST_WIDTH 6
`define CNCFG_ST_RESET 6'h04

// protocol state codes in the state register
`define CNCFG_NMT_PREOP 2'h0
`define CNCFG_NMT_STOPPED 2'h1
`define CNCFG_NMT_OPER 2'h2

// interrupt bits: one step event per handwheel
`define CNCFG_IRQ_WIDTH 3
`define CNCFG_IRQ_MASK_RESET 3'h0

// indicator timing, handwheel count and count width
`define CNCFG_CLK_NS 100
`define CNCFG_TICK_MS 200
`define CNCFG_PHASES 6
`define CNCFG_WHEELS 3
`define CNCFG_COUNT_W 16

`endif

/* File: shared/cncfg_pkg.sv */
package cncfg_pkg;
   typedef enum logic [1:0] {
      CNCFG_RATE_1000,
      CNCFG_RATE_800,
      CNCFG_RATE_500,
      CNCFG_RATE_250
   } cncfg_rate_t;

   typedef logic signed [15:0] cncfg_count_t;
endpackage

/* File: core/cncfg_quad.sv */
`include "cncfg_defs.svh"

module cncfg_quad (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // encoder phases
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   // decoded position
   output cncfg_pkg::cncfg_count_t count_o,
   output logic step_o
);
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] prev_reg;
   cncfg_pkg::cncfg_count_t count_reg;
   logic step_reg;
   logic [2:0] live_reg;

   wire logic moved = sync2_reg != prev_reg;
   // both phases changing at once is a lost edge, not a step;
   // no count until prev_reg holds a real sample, or a pin idling high fakes a step
   wire logic valid_step = live_reg[2] && moved &&
      ((sync2_reg[1] ^ prev_reg[1]) != (sync2_reg[0] ^ prev_reg[0]));
   // a leads b counts up: new a differs from old b
   wire logic up = prev_reg[0] ^ sync2_reg[1];
   wire cncfg_pkg::cncfg_count_t count_next =
      up ? cncfg_pkg::cncfg_count_t'(count_reg + 16'sh0001)
         : cncfg_pkg::cncfg_count_t'(count_reg - 16'sh0001);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         prev_reg <= 2'h0;
         live_reg <= 3'h0;
      end else begin
         live_reg <= {live_reg[1:0], 1'b1};
         sync1_reg <= {phase_a_i, phase_b_i};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_reg <= 16'sh0000;
         step_reg <= 1'b0;
      end else begin
         step_reg <= valid_step;
         if (valid_step) begin
            count_reg <= count_next;
         end
      end
   end

   assign count_o = count_reg;
   assign step_o = step_reg;

   AST_QUAD_UP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      valid_step && up |=> count_reg == $past(count_reg) + 16'sh0001)
      else $error("handwheel count did not rise on forward step");

   AST_QUAD_DOWN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      valid_step && !up |=> count_reg == $past(count_reg) - 16'sh0001)
      else $error("handwheel count did not fall on reverse step");
endmodule // cncfg_quad

/* File: core/cncfg_top.sv */
// Notes on behaviour
// - switch one off proprietary, on CANopen
// - switches two/three pick the CANopen bit rate
// - bit rate sampled only at reset
// - switch four is node number MSB
// - rotary selector gives node low bits
// - lower node number wins the bus
// - node number changes only after reset
// - green blinks preop, flashes stopped, on operational
// - red dark ready, blinks during configuration
// - red single flash at error warning level
// - red double flash on lost communication
// - red steady while controller is bus-off
// - three handwheels, phases A and B
//
// Design decisions made here: the register addresses and the APB slave port.
`include "cncfg_defs.svh"

module cncfg_top #(
   parameter int TICK_CYCLES = `CNCFG_TICK_MS * 1000000 / `CNCFG_CLK_NS
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // configuration switches, high means on
   input wire logic dip_protocol_i,
   input wire logic dip_rate_hi_i,
   input wire logic dip_rate_lo_i,
   input wire logic dip_node_msb_i,
   input wire logic [3:0] rotary_node_i,
   // arbitration against a competing node
   input wire logic [4:0] peer_node_i,
   output logic arb_win_o,
   // configuration towards the bus controller
   output logic canopen_o,
   output cncfg_pkg::cncfg_rate_t rate_o,
   output logic rate_valid_o,
   output logic [4:0] node_id_o,
   // indicators
   output logic led_run_o,
   output logic led_err_o,
   // handwheels
   input wire logic handwheel_one_phase_a_i,
   input wire logic handwheel_one_phase_b_i,
   input wire logic handwheel_two_phase_a_i,
   input wire logic handwheel_two_phase_b_i,
   input wire logic handwheel_three_phase_a_i,
   input wire logic handwheel_three_phase_b_i,
   // interrupt
   output logic irq_o
);
   // switch capture
   logic sampled_reg;
   logic canopen_reg;
   cncfg_pkg::cncfg_rate_t rate_reg;
   logic [4:0] node_reg;
   cncfg_pkg::cncfg_rate_t rate_decode;

   // registers
   logic [`CNCFG_ST_WIDTH-1:0] state_reg;
   logic [`CNCFG_IRQ_WIDTH-1:0] irq_stat_reg;
   logic [`CNCFG_IRQ_WIDTH-1:0] irq_mask_reg;
   logic [31:0] prdata_reg;
   logic hit_reg;

   // indicator timing
   logic [31:0] tick_cnt_reg;
   logic [2:0] phase_reg;
   logic led_run_reg;
   logic led_err_reg;
   logic led_run_next;
   logic led_err_next;

   // handwheels
   cncfg_pkg::cncfg_count_t wheel_count [`CNCFG_WHEELS];
   logic [`CNCFG_WHEELS-1:0] wheel_step;
   logic [`CNCFG_WHEELS-1:0] wheel_a;
   logic [`CNCFG_WHEELS-1:0] wheel_b;

   assign wheel_a = {handwheel_three_phase_a_i, handwheel_two_phase_a_i, handwheel_one_phase_a_i};
   assign wheel_b = {handwheel_three_phase_b_i, handwheel_two_phase_b_i, handwheel_one_phase_b_i};

   for (genvar i = 0; i < `CNCFG_WHEELS; i++) begin : g_wheel
      cncfg_quad u_quad (
         .mclk_i(mclk_i),
         .rst_b_i(rst_b_i),
         .phase_a_i(wheel_a[i]),
         .phase_b_i(wheel_b[i]),
         .count_o(wheel_count[i]),
         .step_o(wheel_step[i])
      );
   end

   // switch decode
   always_comb begin
      unique case ({dip_rate_hi_i, dip_rate_lo_i})
         2'h3: rate_decode = cncfg_pkg::CNCFG_RATE_1000;
         2'h1: rate_decode = cncfg_pkg::CNCFG_RATE_800;
         2'h2: rate_decode = cncfg_pkg::CNCFG_RATE_500;
         2'h0: rate_decode = cncfg_pkg::CNCFG_RATE_250;
      endcase
   end

   // switches are caught once, on the first edge after reset release
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sampled_reg <= 1'b0;
         canopen_reg <= 1'b0;
         rate_reg <= cncfg_pkg::CNCFG_RATE_250;
         node_reg <= 5'h00;
      end else if (!sampled_reg) begin
         sampled_reg <= 1'b1;
         canopen_reg <= dip_protocol_i;
         rate_reg <= rate_decode;
         node_reg <= {dip_node_msb_i, rotary_node_i};
      end
   end

   assign canopen_o = canopen_reg;
   assign rate_o = rate_reg;
   assign rate_valid_o = sampled_reg && canopen_reg;
   assign node_id_o = node_reg;
   assign arb_win_o = sampled_reg && (node_reg < peer_node_i);

   // apb decode
   wire logic setup = psel_i && !penable_i;
   wire logic access = psel_i && penable_i;
   wire logic a_config = paddr_i == `CNCFG_OFF_CONFIG;
   wire logic a_state = paddr_i == `CNCFG_OFF_STATE;
   wire logic a_wheel0 = paddr_i == `CNCFG_OFF_WHEEL0;
   wire logic a_wheel1 = paddr_i == `CNCFG_OFF_WHEEL1;
   wire logic a_wheel2 = paddr_i == `CNCFG_OFF_WHEEL2;
   wire logic a_stat = paddr_i == `CNCFG_OFF_IRQ_STAT;
   wire logic a_mask = paddr_i == `CNCFG_OFF_IRQ_MASK;
   wire logic hit = a_config | a_state | a_wheel0 | a_wheel1 | a_wheel2 | a_stat | a_mask;
   wire logic wr_state = access && pwrite_i && a_state;
   wire logic wr_mask = access && pwrite_i && a_mask;
   wire logic rd_stat = access && !pwrite_i && a_stat;

   wire logic [31:0] cfg_word = {19'h00000, sampled_reg, 3'h0, node_reg, 1'b0, rate_reg, canopen_reg};
   wire logic [31:0] rd_mux =
      a_config ? cfg_word :
      a_state ? {26'h0000000, state_reg} :
      a_wheel0 ? {{16{wheel_count[0][15]}}, wheel_count[0]} :
      a_wheel1 ? {{16{wheel_count[1][15]}}, wheel_count[1]} :
      a_wheel2 ? {{16{wheel_count[2][15]}}, wheel_count[2]} :
      a_stat ? {29'h00000000, irq_stat_reg} :
      a_mask ? {29'h00000000, irq_mask_reg} : 32'h00000000;

   // clear only the bits the read returned, so a step landing meanwhile survives
   wire logic [`CNCFG_IRQ_WIDTH-1:0] stat_clr = rd_stat ? prdata_reg[`CNCFG_IRQ_WIDTH-1:0] : 3'h0;
   wire logic [`CNCFG_IRQ_WIDTH-1:0] irq_stat_next = (irq_stat_reg & ~stat_clr) | wheel_step;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_reg <= 32'h00000000;
         hit_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite_i ? 32'h00000000 : rd_mux;
         hit_reg <= hit;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= `CNCFG_ST_RESET;
         irq_mask_reg <= `CNCFG_IRQ_MASK_RESET;
         irq_stat_reg <= 3'h0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (wr_state) begin
            state_reg <= pwdata_i[`CNCFG_ST_WIDTH-1:0];
         end
         if (wr_mask) begin
            irq_mask_reg <= pwdata_i[`CNCFG_IRQ_WIDTH-1:0];
         end
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = access;
   assign pslverr_o = access && !hit_reg;
   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // indicator frame: six ticks, one flash is one tick lit
   wire logic tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_cnt_reg <= 32'h00000000;
         phase_reg <= 3'h0;
      end else if (tick) begin
         tick_cnt_reg <= 32'h00000000;
         phase_reg <= (phase_reg == 3'(`CNCFG_PHASES - 1)) ? 3'h0 : phase_reg + 3'h1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // equal on and off for blinking; long dark after flashes
   wire logic pat_blink = !phase_reg[0];
   wire logic pat_single = phase_reg == 3'h0;
   wire logic pat_double = (phase_reg == 3'h0) || (phase_reg == 3'h2);

   wire logic [1:0] nmt = state_reg[`CNCFG_ST_NMT_LSB+1:`CNCFG_ST_NMT_LSB];
   wire logic st_config = state_reg[`CNCFG_ST_CONFIG_BIT];
   wire logic st_warn = state_reg[`CNCFG_ST_WARN_BIT];
   wire logic st_lost = state_reg[`CNCFG_ST_LOST_BIT];
   wire logic st_busoff = state_reg[`CNCFG_ST_BUSOFF_BIT];

   always_comb begin
      unique case (nmt)
         `CNCFG_NMT_PREOP: led_run_next = pat_blink;
         `CNCFG_NMT_STOPPED: led_run_next = pat_single;
         `CNCFG_NMT_OPER: led_run_next = 1'b1;
         default: led_run_next = 1'b0;
      endcase
   end

   // worst condition shown first
   always_comb begin
      if (st_busoff) begin
         led_err_next = 1'b1;
      end else if (st_lost) begin
         led_err_next = pat_double;
      end else if (st_warn) begin
         led_err_next = pat_single;
      end else if (st_config) begin
         led_err_next = pat_blink;
      end else begin
         led_err_next = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         led_run_reg <= 1'b0;
         led_err_reg <= 1'b0;
      end else begin
         led_run_reg <= led_run_next;
         led_err_reg <= led_err_next;
      end
   end

   assign led_run_o = led_run_reg;
   assign led_err_o = led_err_reg;

   AST_RATE_FROZEN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sampled_reg |=> $stable(rate_reg) && $stable(canopen_reg))
      else $error("bit rate changed after reset sampling");

   AST_NODE_FROZEN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sampled_reg |=> $stable(node_id_o))
      else $error("node number changed after reset sampling");

   // sampled rst_b_i keeps the release edge out: the capture lands one edge later
   AST_NODE_MAP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && !sampled_reg |=> node_id_o == {$past(dip_node_msb_i), $past(rotary_node_i)})
      else $error("node number not taken from switches");

   AST_RATE_1000: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && !sampled_reg && dip_rate_hi_i && dip_rate_lo_i
      |=> rate_o == cncfg_pkg::CNCFG_RATE_1000)
      else $error("both rate switches on did not give 1000 kHz");

   AST_RATE_500: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && !sampled_reg && dip_rate_hi_i && !dip_rate_lo_i
      |=> rate_o == cncfg_pkg::CNCFG_RATE_500)
      else $error("on/off rate switches did not give 500 kHz");

   AST_PROTOCOL: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rst_b_i && !sampled_reg |=> rate_valid_o == $past(dip_protocol_i))
      else $error("rate validity does not follow protocol switch");

   AST_RUN_OPER: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (nmt == `CNCFG_NMT_OPER) [*2] |-> led_run_o)
      else $error("run indicator dark in operational state");

   AST_ERR_BUSOFF: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      st_busoff [*2] |-> led_err_o)
      else $error("error indicator dark while bus-off");

   AST_ERR_READY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_reg[`CNCFG_ST_BUSOFF_BIT:`CNCFG_ST_CONFIG_BIT] == 4'h0) [*2] |-> !led_err_o)
      else $error("error indicator lit while ready");

   AST_DOUBLE_GAP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (st_lost && !st_busoff && phase_reg == 3'h1) [*2] |-> !led_err_o)
      else $error("double flash has no gap between flashes");

   AST_ERR_WARN_GAP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (st_warn && !st_lost && !st_busoff && phase_reg != 3'h0) [*2] |-> !led_err_o)
      else $error("single flash lit outside its flash tick");
endmodule // cncfg_top

/* File: tb/cncfg_peer.sv */
module cncfg_peer (
   // place of the competing node in the bus order
   input wire logic [4:0] slot_i,
   // rate the central unit runs at, and the rate the node under test took
   input wire logic [1:0] bus_rate_i,
   input wire logic [1:0] node_rate_i,
   // node number that node holds
   output logic [4:0] node_o,
   // the node only talks to the others at the one shared rate
   output logic rate_ok_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // central unit takes 0, the other nodes follow in steps of one
   assign node_o = slot_i;
   assign rate_ok_o = bus_rate_i == node_rate_i;
endmodule // cncfg_peer

/* File: tb/cncfg_top_tb.sv */
`include "cncfg_defs.svh"
module cncfg_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 4;
   localparam int FRAME = TICK * `CNCFG_PHASES;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, arb_win, canopen, rate_valid, led_run, led_err, irq;
   logic [8:0] sw = 9'h000;
   logic [4:0] slot = 5'h00, peer, node_id;
   logic [2:0] wa = 3'h0, wb = 3'h0;
   logic [1:0] bus_rate = 2'h3;
   logic rate_ok;
   cncfg_pkg::cncfg_rate_t rate;
   int fail_count = 0;
   int n_compared = 0;
   // switch rows: {protocol, rate hi, rate lo, node msb, rotary}
   logic [8:0] sw_row [5] = '{9'h180, 9'h11F, 9'h147, 9'h1D0, 9'h0DA};
   logic [2:0] mode_row [5] = '{3'h5, 3'h7, 3'h3, 3'h1, 3'h0};
   logic [4:0] node_row [5] = '{5'h00, 5'h1F, 5'h07, 5'h10, 5'h1A};
   logic [5:0] st_row [7] = '{6'h00, 6'h05, 6'h0A, 6'h13, 6'h3C, 6'h18, 6'h0C};
   int run_row [7] = '{12, 4, 24, 0, 12, 12, 12};
   int err_row [7] = '{0, 12, 4, 8, 24, 8, 4};
   int lit_r, lit_e, up_r, up_e;
   always #50 mclk = ~mclk;
   cncfg_peer peer_model (.slot_i(slot), .bus_rate_i(bus_rate), .node_rate_i(rate),
      .node_o(peer), .rate_ok_o(rate_ok));
   cncfg_top #(.TICK_CYCLES(TICK)) dut (
      .mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .dip_protocol_i(sw[8]),
      .dip_rate_hi_i(sw[7]), .dip_rate_lo_i(sw[6]), .dip_node_msb_i(sw[4]),
      .rotary_node_i(sw[3:0]), .peer_node_i(peer), .arb_win_o(arb_win),
      .canopen_o(canopen), .rate_o(rate), .rate_valid_o(rate_valid), .node_id_o(node_id),
      .led_run_o(led_run), .led_err_o(led_err),
      .handwheel_one_phase_a_i(wa[0]), .handwheel_one_phase_b_i(wb[0]),
      .handwheel_two_phase_a_i(wa[1]), .handwheel_two_phase_b_i(wb[1]),
      .handwheel_three_phase_a_i(wa[2]), .handwheel_three_phase_b_i(wb[2]), .irq_o(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset(input logic [8:0] s, input logic [1:0] r);
      @(posedge mclk);
      rst_b <= 1'b0;
      sw <= s;
      bus_rate <= r;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask
   // quadrature change, held long enough to count as a clean level
   task automatic wheel(input int w, input logic a, input logic b);
      @(posedge mclk);
      wa[w] <= a;
      wb[w] <= b;
      repeat (5) @(posedge mclk);
   endtask
   // one full frame, counted around so the tick phase does not matter
   task automatic led_meas();
      logic [FRAME-1:0] r, e;
      for (int i = 0; i < FRAME; i++) begin
         @(negedge mclk);
         r[i] = led_run;
         e[i] = led_err;
      end
      lit_r = $countones(r);
      lit_e = $countones(e);
      up_r = $countones(r & ~{r[FRAME-2:0], r[FRAME-1]});
      up_e = $countones(e & ~{e[FRAME-2:0], e[FRAME-1]});
      // an unknown level would vanish from the counts
      if ($isunknown({r, e})) lit_r = -1;
   endtask
   initial begin
      #(100 * 20000);
      $display("MISMATCH t=%0t watchdog expired", $time);
      fail_count++;
      close_out();
   end
   initial begin
      repeat (4) @(negedge mclk);
      chk(32'(rate), 32'h3);
      chk({30'h0, led_run, led_err}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         do_reset(sw_row[i], mode_row[i][2:1]);
         chk({29'h0, canopen, rate_valid, sw_row[i][8]}, {29'h0, mode_row[i][0], mode_row[i][0], mode_row[i][0]});
         chk(32'(node_id), 32'(node_row[i]));
         if (mode_row[i][0]) chk(32'(rate), 32'(mode_row[i][2:1]));
         if (mode_row[i][0]) chk(32'(rate_ok), 32'h1);
         apb(1'b0, `CNCFG_OFF_CONFIG, 32'h0);
         chk(rd & 32'h11F7, {19'h0, 1'b1, 3'h0, node_row[i], 1'b0, mode_row[i]});
      end
      // protocol, rate and node switches all differ from the last row
      @(posedge mclk);
      sw <= 9'h125;
      repeat (4) @(negedge mclk);
      chk({24'h0, canopen, rate, node_id}, {24'h0, 1'b0, 2'h0, 5'h1A});
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         slot <= 5'h19 + 5'(i);
         @(negedge mclk);
         chk(32'(arb_win), (i == 2) ? 32'h1 : 32'h0);
      end
      apb(1'b0, `CNCFG_OFF_STATE, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, `CNCFG_OFF_IRQ_MASK, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, `CNCFG_OFF_CONFIG, 32'hFFFFFFFF);
      apb(1'b0, `CNCFG_OFF_CONFIG, 32'h0);
      chk(rd, 32'h000011A0);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, `CNCFG_OFF_STATE, 32'(st_row[i]));
         repeat (3) @(posedge mclk);
         led_meas();
         chk(lit_r, run_row[i]);
         chk(lit_e, err_row[i]);
         chk(up_r + up_e, (run_row[i] % 24) / 4 + (err_row[i] % 24) / 4);
      end
      wheel(0, 1, 0); wheel(0, 1, 1); wheel(0, 0, 1); wheel(0, 0, 0);
      wheel(1, 0, 1); wheel(1, 1, 1);
      wheel(2, 1, 1); wheel(2, 0, 0);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      apb(1'b0, `CNCFG_OFF_WHEEL0, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, `CNCFG_OFF_WHEEL1, 32'h0);
      chk(rd, 32'hFFFFFFFE);
      apb(1'b0, `CNCFG_OFF_WHEEL2, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `CNCFG_OFF_IRQ_MASK, 32'h7);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h1);
      apb(1'b0, `CNCFG_OFF_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0);
      apb(1'b1, `CNCFG_OFF_IRQ_MASK, 32'h3);
      wheel(2, 1, 0);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0);
      apb(1'b1, `CNCFG_OFF_IRQ_MASK, 32'h4);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h1);
      apb(1'b0, `CNCFG_OFF_IRQ_STAT, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, `CNCFG_OFF_WHEEL2, 32'h0);
      chk(rd, 32'h1);
      close_out();
   end
endmodule // cncfg_top_tb
